// ---- core/ftc_map.svh ----
// Register map, field positions and reset values of the fan configuration bank
// Overview of operation
// - Bit7 set: auto mode, remote or both
// - Bit7 clear: bit5 picks duty or RPM
// - Cfg1 bit4 enables fault indicator output
// - Cfg1 bit3 inverts PWM to active high
// - Cfg1 bit2 selects analog tachometer input
// - Cfg1 bit1 enables alert output
// - Cfg1 bit0: sleep or active monitoring
// - Fan control waits for explicit bit0 write
// - Cfg2 bit7 restores defaults, self-clears
// - Cfg2 bit5 enables remote channel interrupts
// - Remote enable resets 0 on diode fault
// - Cfg2 bit4 enables local channel interrupts
// - Cfg2 bit3 masks alert input function
// - Cfg2 bit2 enables tachometer input
// - Cfg2 bit1 enables bus timeout
// - Cfg2 bit0 enables PWM output
// - Fault indicator after five consecutive faults
`ifndef FTC_MAP_SVH
`define FTC_MAP_SVH

// Register offsets
`define FTC_OFS_CFG1     8'h00
`define FTC_OFS_CFG2     8'h01
`define FTC_OFS_STATUS   8'h20
`define FTC_OFS_MASK     8'h21

// Reset values
`define FTC_CFG1_RST     8'h09
`define FTC_CFG2_RST     8'h7F
`define FTC_MASK_RST     8'h00

// Configuration register 1 fields
`define FTC_C1_AUTO      7
`define FTC_C1_SRC_HI    6
`define FTC_C1_SRC_LO    5
`define FTC_C1_FAULT_EN  4
`define FTC_C1_PWM_INV   3
`define FTC_C1_TACH_ANA  2
`define FTC_C1_ALERT_EN  1
`define FTC_C1_MONITOR   0

// Configuration register 2 fields
`define FTC_C2_SOFT_RST  7
`define FTC_C2_UNUSED    6
`define FTC_C2_REM_EN    5
`define FTC_C2_LOC_EN    4
`define FTC_C2_ALRT_MSK  3
`define FTC_C2_TACH_EN   2
`define FTC_C2_TMO_EN    1
`define FTC_C2_PWM_EN    0

// Status and mask fields
`define FTC_ST_FAN_EVT   0
`define FTC_ST_FAULT     1
`define FTC_ST_ALERT_IN  2
`define FTC_ST_START     3
`define FTC_ST_WIDTH     4

// Consecutive faults before the indicator asserts
`define FTC_FAULT_LIMIT  3'h5

`endif

// ---- core/ftc_pkg.sv ----
// Types shared by the fan configuration bank
package ftc_pkg;

   // Fan-speed control mode chosen by configuration register 1
   typedef enum logic [1:0] {
      FTC_MODE_DUTY = 2'b00,
      FTC_MODE_RPM  = 2'b01,
      FTC_MODE_AUTO = 2'b10
   } ftc_mode_t;

   // Temperature source used in automatic mode
   typedef enum logic {
      FTC_SRC_REMOTE = 1'b0,
      FTC_SRC_BOTH   = 1'b1
   } ftc_src_t;

endpackage

// ---- core/ftc_regs.sv ----
// Configuration register bank of the fan and thermal controller
`timescale 1ns/1ps
`include "ftc_map.svh"

module ftc_regs #(
   parameter int FAULT_CNT_W = 3          // Width of the consecutive fault counter
) (
   // Clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   // Register port
   input  wire logic [7:0]         i_addr,
   input  wire logic [7:0]         i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic      [7:0]         o_rdata,
   // Events from the fan and temperature logic
   input  wire logic               i_fan_fault_evt,
   input  wire logic               i_fan_ok_evt,
   input  wire logic               i_diode_fault,
   input  wire logic               i_pwm_raw,
   input  wire logic               i_alert_req,
   // External pins
   input  wire logic               i_tach_pin,
   input  wire logic               i_alert_pin_n,
   output logic                    o_pwm_pin,
   output logic                    o_pwm_oe,
   output logic                    o_fault_pin,
   output logic                    o_fault_oe,
   output logic                    o_alert_pin,
   output logic                    o_alert_oe,
   // Control to the fan and temperature logic
   output ftc_pkg::ftc_mode_t      o_mode,
   output ftc_pkg::ftc_src_t       o_auto_src,
   output logic                    o_monitor_active,
   output logic                    o_fan_ctrl_active,
   output logic                    o_tach_analog,
   output logic                    o_tach_level,
   output logic                    o_remote_irq_en,
   output logic                    o_local_irq_en,
   output logic                    o_smb_timeout_en,
   output logic                    o_force_full,
   // Interrupt
   output logic                    o_irq
);
   import ftc_pkg::*;

   logic [7:0]             cfg1_q;         // Fan mode and output configuration
   logic [7:0]             cfg2_q;         // Channel enable and reset configuration
   logic [3:0]             status_q;       // Sticky event bits
   logic [3:0]             mask_q;         // Interrupt mask, 1 lets a bit through
   logic                   armed_q;        // Fan control started by software
   logic                   soft_rst_q;     // One-cycle soft reset pulse
   logic                   boot_done_q;    // Power-up capture finished
   logic                   diode_fault_q;  // Diode fault seen at power-up
   logic [FAULT_CNT_W-1:0] fault_cnt_q;    // Consecutive fan faults
   logic                   fault_hit_q;    // Five faults reached
   logic [1:0]             tach_sync_q;    // Tachometer synchroniser
   logic [1:0]             alert_sync_q;   // Alert input synchroniser
   logic                   alert_low_q;    // Previous alert input level
   logic [3:0]             events;         // Events this cycle
   logic                   wr_cfg1;        // Write hits register 1
   logic                   wr_cfg2;        // Write hits register 2
   logic                   rd_status;      // Read of the status register
   logic                   alert_in_low;   // Alert pin held low, not masked
   logic [7:0]             cfg2_dflt;      // Default of register 2

   // Address decoding used by several processes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr_cfg1   = i_wr && hit(i_addr, `FTC_OFS_CFG1);
   assign wr_cfg2   = i_wr && hit(i_addr, `FTC_OFS_CFG2);
   assign rd_status = i_rd && hit(i_addr, `FTC_OFS_STATUS);

   // Remote enable default drops when a diode fault was seen at power-up
   always_comb begin
      cfg2_dflt = `FTC_CFG2_RST;
      if (diode_fault_q) begin
         cfg2_dflt[`FTC_C2_REM_EN] = 1'b0;
      end
   end

   // Power-up capture of the diode fault level after reset release
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         boot_done_q   <= 1'b0;
         diode_fault_q <= 1'b0;
      end else if (!boot_done_q) begin
         // Caught once; a soft reset reuses the stored level
         boot_done_q   <= 1'b1;
         diode_fault_q <= i_diode_fault;
      end
   end

   // Soft reset pulse, the stored bit itself never reads back as one
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_cfg2 && i_wdata[`FTC_C2_SOFT_RST];
      end
   end

   // Configuration register 1
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg1_q <= `FTC_CFG1_RST;
      end else if (soft_rst_q) begin
         cfg1_q <= `FTC_CFG1_RST;
      end else if (wr_cfg1) begin
         cfg1_q <= i_wdata;
      end
   end

   // Configuration register 2
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg2_q <= `FTC_CFG2_RST;
      end else if (!boot_done_q) begin
         // Power-up default for the remote channel
         cfg2_q[`FTC_C2_REM_EN] <= !i_diode_fault;
      end else if (soft_rst_q) begin
         cfg2_q <= cfg2_dflt;
      end else if (wr_cfg2) begin
         // Bit 7 self-clears and bit 6 keeps its reset value
         cfg2_q[5:0] <= i_wdata[5:0];
      end
   end

   // Fan control arms only on an explicit write of one to the monitor bit
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_q <= 1'b0;
      end else if (soft_rst_q) begin
         armed_q <= 1'b0;
      end else if (wr_cfg1) begin
         armed_q <= i_wdata[`FTC_C1_MONITOR];
      end
   end

   // Consecutive fan fault counter; a good reading breaks the run until the fifth fault latches
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault_cnt_q <= '0;
         fault_hit_q <= 1'b0;
      end else if (soft_rst_q) begin
         fault_cnt_q <= '0;
         fault_hit_q <= 1'b0;
      end else if (i_fan_fault_evt) begin
         if (fault_cnt_q != FAULT_CNT_W'(`FTC_FAULT_LIMIT)) begin
            fault_cnt_q <= fault_cnt_q + FAULT_CNT_W'(1);
         end
         // Latches on the fifth fault in a row
         if (fault_cnt_q == FAULT_CNT_W'(`FTC_FAULT_LIMIT - 3'h1)) begin
            fault_hit_q <= 1'b1;
         end
      end else if (i_fan_ok_evt && !fault_hit_q) begin
         fault_cnt_q <= '0;
      end
   end

   // Pin synchronisers, the first stage feeds only the second
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tach_sync_q  <= 2'h0;
         alert_sync_q <= 2'h3;
         alert_low_q  <= 1'b0;
      end else begin
         tach_sync_q  <= {tach_sync_q[0], i_tach_pin};
         alert_sync_q <= {alert_sync_q[0], i_alert_pin_n};
         alert_low_q  <= alert_in_low;
      end
   end

   // Alert pin pulled low by another party forces full speed unless masked
   assign alert_in_low = !alert_sync_q[1] && !cfg2_q[`FTC_C2_ALRT_MSK];

   // Event vector
   always_comb begin
      events                   = 4'h0;
      events[`FTC_ST_FAN_EVT]  = i_fan_fault_evt;
      events[`FTC_ST_FAULT]    = i_fan_fault_evt && fault_cnt_q
                                 == FAULT_CNT_W'(`FTC_FAULT_LIMIT - 3'h1);
      events[`FTC_ST_ALERT_IN] = alert_in_low && !alert_low_q;
      events[`FTC_ST_START]    = wr_cfg1 && i_wdata[`FTC_C1_MONITOR] && !armed_q;
   end

   // Sticky status; a new event wins over the clearing read
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= 4'h0;
      end else if (soft_rst_q) begin
         status_q <= 4'h0;
      end else if (rd_status) begin
         status_q <= events;
      end else begin
         status_q <= status_q | events;
      end
   end

   // Interrupt mask
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_q <= 4'h0;
      end else if (soft_rst_q) begin
         mask_q <= 4'h0;
      end else if (i_wr && hit(i_addr, `FTC_OFS_MASK)) begin
         mask_q <= i_wdata[3:0];
      end
   end

   // Read data, valid in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         if (hit(i_addr, `FTC_OFS_CFG1)) begin
            o_rdata <= cfg1_q;
         end else if (hit(i_addr, `FTC_OFS_CFG2)) begin
            o_rdata <= cfg2_q;
         end else if (hit(i_addr, `FTC_OFS_STATUS)) begin
            o_rdata <= {4'h0, status_q};
         end else if (hit(i_addr, `FTC_OFS_MASK)) begin
            o_rdata <= {4'h0, mask_q};
         end else begin
            o_rdata <= 8'h00;
         end
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // PWM pin, polarity and enable; registered to keep the pin glitch free
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pwm_pin <= 1'b1;
         o_pwm_oe  <= 1'b0;
      end else begin
         // Active low when bit 3 is clear: an on phase drives the pin low
         o_pwm_pin <= cfg1_q[`FTC_C1_PWM_INV] ? i_pwm_raw : !i_pwm_raw;
         o_pwm_oe  <= cfg2_q[`FTC_C2_PWM_EN];
      end
   end

   // Open-drain fault indicator and alert output, driven only when low
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fault_oe <= 1'b0;
         o_alert_oe <= 1'b0;
      end else begin
         o_fault_oe <= cfg1_q[`FTC_C1_FAULT_EN] && fault_hit_q;
         o_alert_oe <= cfg1_q[`FTC_C1_ALERT_EN] && (i_alert_req || o_irq);
      end
   end

   assign o_fault_pin = 1'b0;
   assign o_alert_pin = 1'b0;

   // Mode decode: bit 6 matters only in automatic mode
   always_comb begin
      if (cfg1_q[`FTC_C1_AUTO]) begin
         o_mode = FTC_MODE_AUTO;
      end else if (cfg1_q[`FTC_C1_SRC_LO]) begin
         o_mode = FTC_MODE_RPM;
      end else begin
         o_mode = FTC_MODE_DUTY;
      end
   end

   // Mixed source codes 01 and 10 fall back to remote only
   assign o_auto_src = (cfg1_q[6:5] == 2'b11) ? FTC_SRC_BOTH : FTC_SRC_REMOTE;

   // Control levels from register bits; fan control also needs the armed flag, tach level the pin
   assign o_monitor_active  = cfg1_q[`FTC_C1_MONITOR];
   assign o_fan_ctrl_active = cfg1_q[`FTC_C1_MONITOR] && armed_q;
   assign o_tach_analog     = cfg1_q[`FTC_C1_TACH_ANA];
   assign o_tach_level      = tach_sync_q[1] && cfg2_q[`FTC_C2_TACH_EN]
                              && !cfg1_q[`FTC_C1_TACH_ANA];
   assign o_remote_irq_en   = cfg2_q[`FTC_C2_REM_EN];
   assign o_local_irq_en    = cfg2_q[`FTC_C2_LOC_EN];
   assign o_smb_timeout_en  = cfg2_q[`FTC_C2_TMO_EN];
   // Five faults force full speed whether or not the indicator is enabled
   assign o_force_full      = fault_hit_q || alert_low_q;
   assign o_irq             = |(status_q & mask_q);

endmodule

// ---- tb/ftc_regs_properties.sv ----
// Port-level checks on the fan configuration bank
`timescale 1ns/1ps
module ftc_regs_properties #(
   parameter int FAULT_CNT_W = 3      // Mirrors the bank's fault counter width
) (
   // Clock, reset and register port
   input wire logic                i_ref_clk,
   input wire logic                i_rst_n,
   input wire logic [7:0]          i_addr,
   input wire logic [7:0]          i_wdata,
   input wire logic                i_wr,
   input wire logic                i_rd,
   input wire logic [7:0]          o_rdata,
   // Outputs decoded from the configuration
   input wire logic                o_pwm_oe,
   input wire logic                o_fault_oe,
   input wire logic                o_force_full,
   input wire ftc_pkg::ftc_mode_t  o_mode,
   input wire ftc_pkg::ftc_src_t   o_auto_src,
   input wire logic                o_monitor_active,
   input wire logic                o_fan_ctrl_active,
   input wire logic                o_tach_analog,
   input wire logic                o_tach_level,
   input wire logic                o_remote_irq_en,
   input wire logic                o_local_irq_en,
   input wire logic                o_smb_timeout_en
);
   import ftc_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Plain writes to each configuration register
   wire  sr = i_wr && i_addr == 8'h01 && i_wdata[7];
   logic sr_q;                        // Soft reset applying in this cycle
   // A write that meets the applying soft reset is lost, so it is not watched
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sr_q <= 1'b0;
      end else begin
         sr_q <= sr;
      end
   end
   wire  w1 = i_wr && i_addr == 8'h00 && !sr_q;
   wire  w2 = i_wr && i_addr == 8'h01 && !i_wdata[7] && !sr_q;

   a_mode_decode: assert property (w1 |=> o_mode ==
      ($past(i_wdata[7]) ? FTC_MODE_AUTO : $past(i_wdata[5]) ? FTC_MODE_RPM : FTC_MODE_DUTY))
      else $error("mode decode wrong");
   a_auto_source: assert property (w1 |=>
      o_auto_src == ftc_src_t'($past(i_wdata[6:5]) == 2'b11)) else $error("source wrong");
   a_cfg1_flags: assert property (w1 |=> o_fan_ctrl_active == $past(i_wdata[0]) &&
      o_monitor_active == $past(i_wdata[0]) && o_tach_analog == $past(i_wdata[2]))
      else $error("cfg1 flags wrong");
   a_cfg2_flags: assert property (w2 |=> o_remote_irq_en == $past(i_wdata[5]) &&
      o_local_irq_en == $past(i_wdata[4]) && o_smb_timeout_en == $past(i_wdata[1]))
      else $error("cfg2 flags wrong");
   a_pwm_enable: assert property (w2 |-> ##2 o_pwm_oe == $past(i_wdata[0], 2))
      else $error("pwm enable wrong");
   a_soft_restore: assert property (sr |-> ##2 (o_mode == FTC_MODE_DUTY &&
      !o_fan_ctrl_active && o_local_irq_en && o_smb_timeout_en && !o_tach_analog))
      else $error("soft reset left state");
   a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside slot");
   a_fault_order: assert property ($rose(o_fault_oe) |-> $past(o_force_full))
      else $error("indicator before fault latch");
   a_tach_gate: assert property (o_tach_level |-> !o_tach_analog)
      else $error("tach level while analog");
endmodule

// ---- tb/ftc_host.sv ----
// Register-port host that programs the fan configuration bank
`timescale 1ns/1ps
module ftc_host (
   // Clock
   input  wire logic       i_ref_clk,
   // Register port toward the bank
   output logic [7:0]      o_addr  = 8'h00,
   output logic [7:0]      o_wdata = 8'h00,
   output logic            o_wr    = 1'b0,
   output logic            o_rd    = 1'b0,
   input  wire logic [7:0] i_rdata
);
   // One-cycle write; fan control is armed only by such a write
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_ref_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_ref_clk);
      o_wr    <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe, so take them at that edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_ref_clk);
      o_rd   <= 1'b0;
      @(posedge i_ref_clk);
      d = i_rdata;
   endtask
endmodule

// ---- tb/ftc_regs_tb.sv ----
// Self-checking bench for the fan configuration bank
`timescale 1ns/1ps
module ftc_regs_tb;
   import ftc_pkg::*;
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0;          // Clock and async reset
   logic [7:0] i_addr, i_wdata, o_rdata, v, c1, c2; // Port, read value, last cfgs
   logic i_wr, i_rd, b, t, a;
   logic i_fan_fault_evt = 1'b0, i_fan_ok_evt = 1'b0, i_diode_fault = 1'b0;
   logic i_pwm_raw = 1'b0, i_alert_req = 1'b0, i_tach_pin = 1'b0, i_alert_pin_n = 1'b1;
   logic o_pwm_pin, o_pwm_oe, o_fault_pin, o_fault_oe, o_alert_pin, o_alert_oe, o_irq;
   logic o_monitor_active, o_fan_ctrl_active, o_tach_analog, o_tach_level, o_force_full;
   logic o_remote_irq_en, o_local_irq_en, o_smb_timeout_en;
   ftc_mode_t o_mode;
   ftc_src_t  o_auto_src;
   int fail_count = 0, total_checks = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   ftc_regs dut (.*);
   ftc_host u_host (.i_ref_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
                    .o_rd(i_rd), .i_rdata(o_rdata));

   // Compare seen against expected
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Let n edges pass, then sample settled outputs
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   // n one-cycle event pulses: good tach reading or fan fault
   task automatic evt(input bit ok, input int n);
      repeat (n) begin
         @(posedge i_ref_clk);
         if (ok) i_fan_ok_evt <= 1'b1;
         else i_fan_fault_evt <= 1'b1;
         @(posedge i_ref_clk);
         i_fan_ok_evt    <= 1'b0;
         i_fan_fault_evt <= 1'b0;
      end
   endtask
   // Mode expected from a cfg1 value
   function automatic logic [7:0] exp_mode(input logic [7:0] c);
      return c[7] ? 8'h02 : {7'h00, c[5]};
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog: the tests need a few hundred cycles
   initial begin
      #500000;
      fail_count++;
      final_report();
   end

   initial begin
      void'($urandom(32'hFBADB889));
      repeat (4) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      cyc(3);
      u_host.rd(8'h00, v);
      chk("cfg1", v, 8'h09);
      u_host.rd(8'h01, v);
      chk("cfg2", v, 8'h7F);
      chk("fan_active", {7'h00, o_fan_ctrl_active}, 8'h00);
      chk("od_pins", {6'h00, o_fault_pin, o_alert_pin}, 8'h00);
      u_host.wr(8'h55, 8'hFF);
      u_host.rd(8'h55, v);
      chk("unmapped", v, 8'h00);
      // Interrupt raised, read-cleared, then masked
      u_host.wr(8'h21, 8'h01);
      evt(0, 1);
      cyc(2);
      chk("irq", {7'h00, o_irq}, 8'h01);
      u_host.rd(8'h20, v);
      chk("status", v, 8'h01);
      cyc(2);
      chk("irq_clr", {7'h00, o_irq}, 8'h00);
      u_host.wr(8'h21, 8'h00);
      evt(0, 1);
      cyc(2);
      chk("irq_msk", {7'h00, o_irq}, 8'h00);
      u_host.rd(8'h20, v);
      // Random configurations, read back and decoded outputs; mask is zero here
      repeat (16) begin
         c1 = 8'($urandom);
         c2 = 8'($urandom) & 8'h7F;
         b  = 1'($urandom);
         t  = 1'($urandom);
         a  = 1'($urandom);
         u_host.wr(8'h00, c1);
         u_host.wr(8'h01, c2);
         i_pwm_raw   <= b;
         i_tach_pin  <= t;
         i_alert_req <= a;
         u_host.rd(8'h00, v);
         chk("cfg1", v, c1);
         u_host.rd(8'h01, v);
         chk("cfg2", v, {2'b01, c2[5:0]});
         cyc(1);
         chk("mode", {6'h00, o_mode}, exp_mode(c1));
         chk("src", {7'h00, o_auto_src}, {7'h00, c1[6] & c1[5]});
         chk("pwm_pin", {7'h00, o_pwm_pin}, {7'h00, b ^ ~c1[3]});
         chk("pwm_oe", {7'h00, o_pwm_oe}, {7'h00, c2[0]});
         chk("tach", {7'h00, o_tach_level}, {7'h00, t & c2[2] & ~c1[2]});
         chk("tach_ana", {7'h00, o_tach_analog}, {7'h00, c1[2]});
         chk("mon", {7'h00, o_monitor_active}, {7'h00, c1[0]});
         chk("fan_ctl", {7'h00, o_fan_ctrl_active}, {7'h00, c1[0]});
         chk("alert_oe", {7'h00, o_alert_oe}, {7'h00, a & c1[1]});
         chk("irq_en", {6'h00, o_remote_irq_en, o_local_irq_en}, {6'h00, c2[5:4]});
         chk("tmo_en", {7'h00, o_smb_timeout_en}, {7'h00, c2[1]});
      end
      // Soft reset restores defaults and clears itself
      u_host.wr(8'h01, 8'h80);
      cyc(4);
      u_host.rd(8'h00, v);
      chk("cfg1_sr", v, 8'h09);
      u_host.rd(8'h01, v);
      chk("cfg2_sr", v, 8'h7F);
      chk("fan_sr", {7'h00, o_fan_ctrl_active}, 8'h00);
      // Alert pin input only forces full speed when unmasked
      i_alert_pin_n <= 1'b0;
      cyc(6);
      chk("force_msk", {7'h00, o_force_full}, 8'h00);
      u_host.wr(8'h01, 8'h37);
      cyc(6);
      chk("force_in", {7'h00, o_force_full}, 8'h01);
      @(posedge i_ref_clk);
      i_alert_pin_n <= 1'b1;
      cyc(6);
      chk("force_off", {7'h00, o_force_full}, 8'h00);
      // Four faults, a good reading, four more: no latch; the fifth in a row latches
      u_host.wr(8'h00, 8'h11);
      evt(1, 1);
      evt(0, 4);
      evt(1, 1);
      evt(0, 4);
      cyc(4);
      chk("force_4", {7'h00, o_force_full}, 8'h00);
      chk("fault_4", {7'h00, o_fault_oe}, 8'h00);
      evt(0, 1);
      cyc(3);
      chk("force_5", {7'h00, o_force_full}, 8'h01);
      chk("fault_5", {7'h00, o_fault_oe}, 8'h01);
      // Fan event, fifth fault, alert pin edge and start all seen since soft reset
      u_host.rd(8'h20, v);
      chk("status_all", v, 8'h0F);
      // Indicator gated off by bit 4 while full speed stays forced
      u_host.wr(8'h00, 8'h01);
      cyc(2);
      chk("fault_gate", {7'h00, o_fault_oe}, 8'h00);
      chk("force_gate", {7'h00, o_force_full}, 8'h01);
      // Diode fault at power-up clears the remote enable
      @(posedge i_ref_clk);
      i_rst_n       <= 1'b0;
      i_diode_fault <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      cyc(3);
      u_host.rd(8'h01, v);
      chk("cfg2_diode", v, 8'h5F);
      final_report();
   end
endmodule

bind ftc_regs ftc_regs_properties #(.FAULT_CNT_W(FAULT_CNT_W)) u_chk (.*);
